/* logic/aesh_regs.svh */
`ifndef AESH_REGS_SVH
`define AESH_REGS_SVH

`define AESH_OFS_PTR 8'h08
`define AESH_OFS_STATUS 8'h0C
`define AESH_OFS_IRQ_SET 8'h10
`define AESH_OFS_IRQ_CLR 8'h14
`define AESH_OFS_IRQ_MASK 8'h18
`define AESH_OFS_KEY 8'h20
`define AESH_OFS_IV 8'h40
`define AESH_OFS_DIN 8'h50
`define AESH_OFS_DOUT 8'h60
`define AESH_OFS_SEED 8'h70
`define AESH_OFS_CAP 8'hF8
`define AESH_OFS_REV 8'hFC

`define AESH_BIT_IN_READY 16
`define AESH_BIT_OUT_READY 0
`define AESH_POS_IPTR 0
`define AESH_POS_OPTR 4
`define AESH_POS_COUNTERMEASURE 8
`define AESH_POS_OPMODE 4
`define AESH_POS_KEYLEN 0
`define AESH_POS_VERSION 0
`define AESH_POS_VARIANT 16

`define AESH_RST_WORD 32'h0000_0000
`define AESH_RST_LFSR 32'h0000_0001
`define AESH_LFSR_POLY 32'h8020_0003

`endif

/* logic/aesh_pkg.sv */
package aesh_pkg;

   typedef struct packed {
      logic [3:0][31:0] word;
      logic [3:0] filled;
      logic [1:0] ptr;
   } aesh_ibuf_st_t;

   typedef struct packed {
      logic [7:0][31:0] key;
      logic [3:0][31:0] iv;
      logic [3:0][31:0] obuf;
      logic [3:0] unread;
      logic [1:0] optr;
      logic mask_in;
      logic mask_out;
      logic out_ready;
      logic [31:0] rdata;
      logic irq;
   } aesh_top_st_t;

endpackage : aesh_pkg

/* logic/aesh_ibuf_if.sv */
`timescale 1ns/1ps
interface aesh_ibuf_if;
   logic wr;
   logic [31:0] wdata;
   logic ptr_load;
   logic [1:0] ptr_val;
   logic take;
   logic [1:0] ptr;
   logic ready;
   logic [127:0] block;

   modport ctl (output wr, wdata, ptr_load, ptr_val, take, input ptr, ready, block);
   modport buf_side (input wr, wdata, ptr_load, ptr_val, take, output ptr, ready, block);
endinterface : aesh_ibuf_if

/* logic/aesh_ibuf.sv */
`timescale 1ns/1ps
`include "aesh_regs.svh"
module aesh_ibuf (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // control side
   aesh_ibuf_if.buf_side ib
);
   aesh_pkg::aesh_ibuf_st_t st;
   aesh_pkg::aesh_ibuf_st_t next_st;

   always_comb begin
      next_st = st;
      if (ib.ptr_load) begin
         next_st.ptr = ib.ptr_val;
      end else if (ib.wr && !(&st.filled)) begin
         next_st.word[st.ptr] = ib.wdata;
         next_st.filled[st.ptr] = 1'b1;
         next_st.ptr = st.ptr + 2'd1;
      end
      if (ib.take && (&st.filled)) begin
         next_st.filled = 4'h0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign ib.ptr = st.ptr;
   assign ib.ready = !(&st.filled);
   assign ib.block = st.word;
endmodule : aesh_ibuf

/* logic/aesh_deterministic_random_generator.sv */
`timescale 1ns/1ps
`include "aesh_regs.svh"
module aesh_lfsr #(
   parameter logic [31:0] POLY = `AESH_LFSR_POLY
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // seed load
   input wire logic seed_wr_i,
   input wire logic [31:0] seed_i,
   // random word
   output logic [31:0] rnd_o
);
   typedef struct packed {
      logic [31:0] lfsr;
   } aesh_lfsr_st_t;

   aesh_lfsr_st_t st;
   aesh_lfsr_st_t next_st;

   always_comb begin
      next_st = st;
      if (seed_wr_i) begin
         // zero seed would lock the register, so bit 0 is forced
         next_st.lfsr = (seed_i == 32'h0000_0000) ? 32'h0000_0001 : seed_i;
      end else if (st.lfsr[0]) begin
         next_st.lfsr = (st.lfsr >> 1) ^ POLY;
      end else begin
         next_st.lfsr = st.lfsr >> 1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         st.lfsr <= `AESH_RST_LFSR;
      end else begin
         st <= next_st;
      end
   end

   assign rnd_o = st.lfsr;
endmodule : aesh_lfsr

/* logic/aesh_top.sv */
`timescale 1ns/1ps
`include "aesh_regs.svh"
module aesh_top #(
   parameter logic [2:0] OPMODE_CAP = 3'd4,
   parameter logic [1:0] KEYLEN_CAP = 2'd0,
   parameter logic COUNTERMEASURE_CAP = 1'b1,
   // arbitrary value
   parameter logic [11:0] VERSION_NUM = 12'h0A5,
   // arbitrary value
   parameter logic [3:0] VARIANT_NUM = 4'h0
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   // cipher core side
   output logic [255:0] core_key_o,
   output logic [127:0] core_iv_o,
   output logic [127:0] core_in_block_o,
   output logic core_in_valid_o,
   input wire logic core_take_i,
   input wire logic core_done_i,
   input wire logic [127:0] core_result_i,
   output logic [31:0] core_rnd_o,
   // interrupt
   output logic irq_o
);
   ////////////////////////////////////////////////////////////////////////////
   aesh_pkg::aesh_top_st_t st;
   aesh_pkg::aesh_top_st_t next_st;
   aesh_ibuf_if ib ();

   logic wr_key;
   logic wr_iv;
   logic [2:0] key_idx;
   logic [1:0] iv_idx;
   logic in_flag;

   assign key_idx = reg_addr_i[4:2];
   assign iv_idx = reg_addr_i[3:2];
   assign wr_key = reg_wr_i && (reg_addr_i[7:5] == 3'(`AESH_OFS_KEY >> 5)) && (reg_addr_i[1:0] == 2'b00);
   assign wr_iv = reg_wr_i && (reg_addr_i[7:4] == 4'(`AESH_OFS_IV >> 4)) && (reg_addr_i[1:0] == 2'b00);

   ////////////////////////////////////////////////////////////////////////////
   // input buffer control
   always_comb begin
      ib.wr = reg_wr_i && (reg_addr_i == `AESH_OFS_DIN);
      ib.wdata = reg_wdata_i;
      ib.ptr_load = reg_wr_i && (reg_addr_i == `AESH_OFS_PTR);
      ib.ptr_val = reg_wdata_i[`AESH_POS_IPTR +: 2];
      ib.take = core_take_i;
   end

   aesh_ibuf u_ibuf (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .ib(ib)
   );

   aesh_lfsr u_lfsr (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .seed_wr_i(reg_wr_i && (reg_addr_i == `AESH_OFS_SEED)),
      .seed_i(reg_wdata_i),
      .rnd_o(core_rnd_o)
   );

   assign in_flag = ib.ready;

   ////////////////////////////////////////////////////////////////////////////
   // register state
   always_comb begin
      next_st = st;
      if (wr_key) begin
         next_st.key[key_idx] = reg_wdata_i;
      end
      if (wr_iv) begin
         next_st.iv[iv_idx] = reg_wdata_i;
      end
      if (reg_wr_i && (reg_addr_i == `AESH_OFS_IRQ_SET)) begin
         next_st.mask_in = st.mask_in | reg_wdata_i[`AESH_BIT_IN_READY];
         next_st.mask_out = st.mask_out | reg_wdata_i[`AESH_BIT_OUT_READY];
      end
      if (reg_wr_i && (reg_addr_i == `AESH_OFS_IRQ_CLR)) begin
         next_st.mask_in = st.mask_in & ~reg_wdata_i[`AESH_BIT_IN_READY];
         next_st.mask_out = st.mask_out & ~reg_wdata_i[`AESH_BIT_OUT_READY];
      end
      if (reg_wr_i && (reg_addr_i == `AESH_OFS_PTR)) begin
         next_st.optr = reg_wdata_i[`AESH_POS_OPTR +: 2];
      end
      // output port read
      next_st.rdata = `AESH_RST_WORD;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `AESH_OFS_PTR: begin
               next_st.rdata[`AESH_POS_OPTR +: 2] = st.optr;
               next_st.rdata[`AESH_POS_IPTR +: 2] = ib.ptr;
            end
            `AESH_OFS_STATUS: begin
               next_st.rdata[`AESH_BIT_IN_READY] = in_flag;
               next_st.rdata[`AESH_BIT_OUT_READY] = st.out_ready;
            end
            `AESH_OFS_IRQ_MASK: begin
               next_st.rdata[`AESH_BIT_IN_READY] = st.mask_in;
               next_st.rdata[`AESH_BIT_OUT_READY] = st.mask_out;
            end
            `AESH_OFS_DOUT: begin
               next_st.rdata = st.obuf[st.optr];
               next_st.unread[st.optr] = 1'b0;
               next_st.optr = st.optr + 2'd1;
            end
            `AESH_OFS_CAP: begin
               next_st.rdata[`AESH_POS_COUNTERMEASURE] = COUNTERMEASURE_CAP;
               next_st.rdata[`AESH_POS_OPMODE +: 3] = OPMODE_CAP;
               next_st.rdata[`AESH_POS_KEYLEN +: 2] = KEYLEN_CAP;
            end
            `AESH_OFS_REV: begin
               next_st.rdata[`AESH_POS_VERSION +: 12] = VERSION_NUM;
               next_st.rdata[`AESH_POS_VARIANT +: 4] = VARIANT_NUM;
            end
            default: begin
               next_st.rdata = `AESH_RST_WORD;
            end
         endcase
      end
      if (st.out_ready && (next_st.unread == 4'h0)) begin
         next_st.out_ready = 1'b0;
      end
      // new result wins over a read in the same cycle
      if (core_done_i) begin
         next_st.obuf = core_result_i;
         next_st.unread = 4'hF;
         next_st.out_ready = 1'b1;
      end
      next_st.irq = (in_flag && next_st.mask_in) || (next_st.out_ready && next_st.mask_out);
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign reg_rdata_o = st.rdata;
   assign core_key_o = st.key;
   assign core_iv_o = st.iv;
   assign core_in_block_o = ib.block;
   assign core_in_valid_o = !ib.ready;
   assign irq_o = st.irq;
endmodule : aesh_top

/* dv/aesh_core_model.sv */
`timescale 1ns/1ps
module aesh_core_model (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // block side
   input wire logic valid_i,
   input wire logic [127:0] block_i,
   input wire logic [127:0] key_i,
   output logic take_o,
   output logic done_o,
   output logic [127:0] result_o
);
   logic [3:0] cnt;
   logic [127:0] res;
   // inverted data outside the done pulse
   assign result_o = done_o ? res : ~res;
   always @(posedge ref_clk_i) begin
      take_o <= 1'h0;
      done_o <= 1'h0;
      if (!rst_n_i) begin
         cnt <= 4'h0;
      end else if (cnt != 4'h0) begin
         cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
         take_o <= (cnt == 4'h5);
         done_o <= (cnt == 4'h9);
      end else if (valid_i) begin
         cnt <= 4'h1;
         res <= block_i ^ key_i;
      end
   end
endmodule : aesh_core_model

/* dv/aesh_top_checker.sv */
`timescale 1ns/1ps
module aesh_top_checker #(
   parameter logic [2:0] OPMODE_CAP = 3'h4,
   parameter logic [1:0] KEYLEN_CAP = 2'h0,
   parameter logic COUNTERMEASURE_CAP = 1'h1
) (
   // watched ports
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic [127:0] core_in_block_o,
   input wire logic core_in_valid_o,
   input wire logic core_take_i,
   input wire logic [31:0] core_rnd_o,
   input wire logic irq_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   AST_FULL_HOLD: assert property (core_in_valid_o && !core_take_i |=> core_in_valid_o)
      else $error("input buffer left full state untaken");
   AST_TAKE_EMPTY: assert property (core_in_valid_o && core_take_i |=> !core_in_valid_o)
      else $error("input buffer not emptied");
   AST_REFUSED: assert property (reg_wr_i && reg_addr_i == 8'h50 && core_in_valid_o && !core_take_i
      |=> $stable(core_in_block_o)) else $error("full buffer overwritten");
   AST_IER_IRQ: assert property (reg_wr_i && reg_addr_i == 8'h10 && reg_wdata_i[16]
      ##1 !core_in_valid_o [*3] |-> irq_o) else $error("irq missing");
   AST_IDR_IRQ: assert property (reg_wr_i && reg_addr_i == 8'h14 && reg_wdata_i == 32'h0001_0001
      |-> ##3 !irq_o) else $error("irq not masked");
   AST_SEED: assert property (reg_wr_i && reg_addr_i == 8'h70 && reg_wdata_i != 32'h0000_0000
      |=> core_rnd_o == $past(reg_wdata_i)) else $error("seed not loaded");
   AST_CAP: assert property (reg_rd_i && reg_addr_i == 8'hF8
      |=> reg_rdata_o == {23'h0, COUNTERMEASURE_CAP, 1'h0, OPMODE_CAP, 2'h0, KEYLEN_CAP}) else $error("capability");
   AST_KEY_WO: assert property (reg_rd_i && reg_addr_i[7:5] == 3'h1 |=> reg_rdata_o == 32'h0000_0000)
      else $error("key readable");
   AST_RD_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
      else $error("read data not idle");
   cover property (reg_wr_i && reg_addr_i == 8'h50 && core_in_valid_o);
   cover property (core_in_valid_o && core_take_i);
   cover property (reg_rd_i && reg_addr_i == 8'h60);
endmodule : aesh_top_checker
bind aesh_top aesh_top_checker #(.OPMODE_CAP(OPMODE_CAP), .KEYLEN_CAP(KEYLEN_CAP),
   .COUNTERMEASURE_CAP(COUNTERMEASURE_CAP)) chk_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .core_in_block_o(core_in_block_o), .core_in_valid_o(core_in_valid_o),
   .core_take_i(core_take_i), .core_rnd_o(core_rnd_o), .irq_o(irq_o));

/* dv/test_aes_host_register_interface.sv */
`timescale 1ns/1ps
module test_aes_host_register_interface;
   logic ref_clk_i, rst_n_i, reg_wr_i, reg_rd_i, core_take_i, core_done_i, irq_o, core_in_valid_o;
   logic [7:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, core_rnd_o;
   logic [255:0] core_key_o, ek;
   logic [127:0] core_iv_o, core_in_block_o, core_result_i, ev, eb, er;
   int error_cnt, comparisons, i;
   aesh_top uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .core_key_o(core_key_o),
      .core_iv_o(core_iv_o), .core_in_block_o(core_in_block_o), .core_in_valid_o(core_in_valid_o),
      .core_take_i(core_take_i), .core_done_i(core_done_i), .core_result_i(core_result_i),
      .core_rnd_o(core_rnd_o), .irq_o(irq_o));
   aesh_core_model core (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .valid_i(core_in_valid_o),
      .block_i(core_in_block_o), .key_i(core_key_o[127:0]), .take_o(core_take_i), .done_o(core_done_i),
      .result_o(core_result_i));
   ////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [255:0] e, input logic [255:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      #1;
      reg_wr_i = 1'h1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(posedge ref_clk_i);
      #1;
      reg_wr_i = 1'h0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk_i);
      #1;
      reg_rd_i = 1'h1;
      reg_addr_i = a;
      @(posedge ref_clk_i);
      #1;
      reg_rd_i = 1'h0;
      chk($sformatf("read %h", a), {224'h0, e}, {224'h0, reg_rdata_o});
   endtask : rd
   task report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////
   initial begin
      ref_clk_i = 1'h0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      {rst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
      repeat (2) @(posedge ref_clk_i);
      #1;
      rst_n_i = 1'h1;
      rd(8'h0C, 32'h0001_0000);
      rd(8'h18, 32'h0000_0000);
      rd(8'hF8, 32'h0000_0140);
      rd(8'hFC, 32'h0000_00A5);
      rd(8'h80, 32'h0000_0000);
      rd(8'h24, 32'h0000_0000);
      wr(8'h10, 32'h0001_0001);
      wr(8'h14, 32'h0000_0001);
      rd(8'h18, 32'h0001_0000);
      chk("irq", 256'h1, {255'h0, irq_o});
      $display("test masks done");
      for (i = 0; i < 8; i++) begin
         ek[32*i +: 32] = 32'(i) * 32'h1111_1111 + 32'h0F00_0001;
         wr(8'h20 + 8'(4*i), ek[32*i +: 32]);
         if (i < 4) begin
            ev[32*i +: 32] = ~ek[32*i +: 32];
            wr(8'h40 + 8'(4*i), ev[32*i +: 32]);
         end
      end
      chk("key", ek, core_key_o);
      chk("iv", {128'h0, ev}, {128'h0, core_iv_o});
      wr(8'h70, 32'h1234_5678);
      wr(8'h08, 32'h0000_0002);
      for (i = 0; i < 4; i++) begin
         eb[32*((i+2)%4) +: 32] = 32'hC0DE_0000 + 32'(i);
         wr(8'h50, 32'hC0DE_0000 + 32'(i));
      end
      wr(8'h50, 32'hDEAD_BEEF);
      rd(8'h0C, 32'h0000_0000);
      chk("irq", 256'h0, {255'h0, irq_o});
      chk("block", {128'h0, eb}, {128'h0, core_in_block_o});
      i = 0;
      while (core_done_i !== 1'h1 && i < 60) begin
         @(posedge ref_clk_i);
         #1;
         i++;
      end
      if (core_done_i !== 1'h1) begin
         error_cnt++;
         $display("ERROR done wait expected 1 seen 0");
         report_and_stop();
      end
      rd(8'h0C, 32'h0001_0001);
      wr(8'h08, 32'h0000_0010);
      rd(8'h08, 32'h0000_0010);
      er = eb ^ ek[127:0];
      for (i = 0; i < 3; i++) rd(8'h60, er[32*((i+1)%4) +: 32]);
      rd(8'h0C, 32'h0001_0001);
      rd(8'h60, er[31:0]);
      rd(8'h0C, 32'h0001_0000);
      wr(8'h14, 32'h0001_0001);
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk("irq", 256'h0, {255'h0, irq_o});
      $display("test data path done");
      report_and_stop();
   end
endmodule : test_aes_host_register_interface
